/* core/mode_ctrl_cfg.svh */
// offsets, field positions, reset values and decoding constants for the mode control block
`ifndef MODE_CTRL_CFG_SVH
`define MODE_CTRL_CFG_SVH
`define OFS_PRIMARY_CFG    8'h00
`define OFS_EXT_CFG        8'h04
`define OFS_STATUS_CFG     8'h08
`define OFS_COMMAND        8'h0C
`define OFS_STATE          8'h10
`define PRIMARY_CFG_RESET  16'h0000
`define EXT_CFG_RESET      16'h0000
`define STATUS_CFG_RESET   16'h0000
`define PC_MODE_HI         15
`define PC_MODE_LO         14
`define PC_AREA            13
`define PC_MSG_MON         12
`define PC_MSG_ERR_HALT    12
`define PC_FRM_ERR_HALT    11
`define PC_STS_MSG_HALT    10
`define PC_STS_FRM_HALT    9
`define PC_AUTO_REPEAT     8
`define PC_RO_MASK         16'h0007
`define EC_EXT_EN          15
`define EC_ALT_STATUS      5
`define SC_MASKING         12
`define SC_BCAST_MASK      11
`define CMD_START          0
`define CMD_STOP           1
`define CMD_SOFT_RESET     2
`define CW_MASK_HI         14
`define CW_MASK_LO         9
`define CW_BCAST           3
`define AREA_A_STACK       16'h0100
`define AREA_A_COUNT       16'h0101
`define AREA_B_STACK       16'h0104
`define AREA_B_COUNT       16'h0105
`endif

/* core/mode_ctrl_pkg.sv */
// types shared by the mode control block and its neighbours
package mode_ctrl_pkg;
	typedef enum logic [3:0] {
		MODE_BC_PLAIN,
		MODE_BC_EXT,
		MODE_WORD_MON,
		MODE_MSG_MON,
		MODE_RT_PLAIN,
		MODE_RT_EXT,
		MODE_RT_MON,
		MODE_IDLE
	} op_mode_t;

	typedef struct packed {
		logic        msg_end;
		logic        word_err;
		logic        format_err;
		logic        timeout;
		logic        loop_fail;
		logic        retry_next;
		logic [7:0]  rt_status;
		logic [15:0] ctrl_word;
		logic        frame_end;
	} msg_evt_t;

	typedef struct packed {
		logic [15:0] stack_addr;
		logic [15:0] count_addr;
	} area_ptr_t;
endpackage : mode_ctrl_pkg

/* core/mode_ctrl.sv */
// configuration register bank, mode decode and bus controller halt control
`timescale 1ns/100ps
`default_nettype none
`include "mode_ctrl_cfg.svh"
module mode_ctrl #(
	parameter bit FULL_FUNCTION = 1'b1
) (
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic                   msg_active,
	input  wire logic                   frame_active,
	input  wire mode_ctrl_pkg::msg_evt_t evt,
	output mode_ctrl_pkg::op_mode_t     mode_q,
	output logic                        abort_q,
	output logic                        bc_running_q,
	output logic                        halt_q,
	output logic                        area_q,
	output mode_ctrl_pkg::area_ptr_t    ptr_q,
	output logic                        alt_status_q
);
	import mode_ctrl_pkg::*;

	logic        rst_s1_q;
	logic        rst_sync_n;
	logic [15:0] pcfg_q;
	logic [15:0] ecfg_q;
	logic [15:0] scfg_q;
	logic        frm_err_q;
	logic        frm_sts_q;
	logic        stop_req_q;

	// reset release through two stages, assertion stays asynchronous
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_q   <= 1'b1;
			rst_sync_n <= rst_s1_q;
		end
	end

	function automatic op_mode_t decode_mode(input logic [15:0] pc, input logic ext,
			input logic full);
		op_mode_t m;
		m = MODE_IDLE;
		case ({pc[`PC_MODE_HI], pc[`PC_MODE_LO]})
			2'b00: m = !full ? MODE_IDLE : (ext ? MODE_BC_EXT : MODE_BC_PLAIN);
			2'b01: m = (pc[`PC_MSG_MON] && ext) ? MODE_MSG_MON : MODE_WORD_MON;
			2'b10: m = !ext ? MODE_RT_PLAIN :
				(pc[`PC_MSG_MON] ? MODE_RT_MON : MODE_RT_EXT);
			2'b11: m = MODE_IDLE;
			default: m = MODE_IDLE;
		endcase
		return m;
	endfunction : decode_mode

	function automatic logic is_bc(input op_mode_t m);
		return (m == MODE_BC_PLAIN) || (m == MODE_BC_EXT);
	endfunction : is_bc

	function automatic logic is_rt(input op_mode_t m);
		return (m == MODE_RT_PLAIN) || (m == MODE_RT_EXT) || (m == MODE_RT_MON);
	endfunction : is_rt

	// bus decode
	wire        wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire        wr_lo     = wb_req && wb_we_i && wb_sel_i[0];
	wire        wr_hi     = wb_req && wb_we_i && wb_sel_i[1];
	wire        sel_pcfg  = (wb_adr_i == `OFS_PRIMARY_CFG);
	wire        sel_ecfg  = (wb_adr_i == `OFS_EXT_CFG);
	wire        sel_scfg  = (wb_adr_i == `OFS_STATUS_CFG);
	wire        sel_cmd   = (wb_adr_i == `OFS_COMMAND);
	wire        sel_state = (wb_adr_i == `OFS_STATE);
	wire        cmd_start = wr_lo && sel_cmd && wb_dat_i[`CMD_START];
	wire        cmd_stop  = wr_lo && sel_cmd && wb_dat_i[`CMD_STOP];
	wire        soft_rst  = wr_lo && sel_cmd && wb_dat_i[`CMD_SOFT_RESET];
	wire        ext_en    = ecfg_q[`EC_EXT_EN];

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic lo, input logic hi);
		return {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
	endfunction : merge16

	// mode change handling
	wire op_mode_t new_mode  = decode_mode(pcfg_q, ext_en, FULL_FUNCTION);
	wire           rt_swap   = is_rt(mode_q) && is_rt(new_mode) &&
		((mode_q == MODE_RT_MON) != (new_mode == MODE_RT_MON));
	wire           hold_mode = msg_active && rt_swap;
	wire           leave_rt  = (is_rt(mode_q) || mode_q == MODE_WORD_MON ||
		mode_q == MODE_MSG_MON) && (is_bc(new_mode) || new_mode == MODE_IDLE);
	// plain RT going idle lets the message run out; nothing is cut short
	wire           quiet_idl = (mode_q == MODE_RT_PLAIN) && (new_mode == MODE_IDLE);
	wire           do_abort  = msg_active && (new_mode != mode_q) && !quiet_idl &&
		(leave_rt || (is_bc(mode_q) && new_mode == MODE_IDLE));
	wire op_mode_t mode_d    = hold_mode ? mode_q : new_mode;

	// area select: frozen while a BC frame or, outside BC modes, a message is open, ignored in word monitor
	wire area_busy = (is_bc(mode_q) && frame_active) || (!is_bc(mode_q) && msg_active);
	wire area_d    = (area_busy || mode_q == MODE_WORD_MON) ? area_q : pcfg_q[`PC_AREA];
	// one next value feeds both the area flag and the pointers, so a soft reset cannot split them
	wire area_nx   = soft_rst ? 1'b0 : area_d;

	// status set evaluation
	wire [7:0] sts_mask = {evt.ctrl_word[`CW_MASK_HI:`CW_MASK_LO], 2'b00};
	wire       bc_bit   = evt.ctrl_word[`CW_BCAST];
	wire       bc_rx    = evt.rt_status[0];
	wire       bc_flag  = scfg_q[`SC_BCAST_MASK] ? (!bc_bit && bc_rx) :
		(bc_rx != bc_bit);
	wire       rest_flg = scfg_q[`SC_MASKING] ? |(evt.rt_status[7:1] & ~sts_mask[7:1]) :
		|evt.rt_status[7:1];
	wire       bcm_flg  = scfg_q[`SC_MASKING] ? (bc_rx && !bc_bit) : bc_flag;
	wire       sts_set  = rest_flg || bcm_flg;
	wire       any_err  = evt.word_err || evt.format_err || evt.timeout || evt.loop_fail;

	// boundary events, a pending retry suppresses the message halt decision; frame and stop halts still apply
	wire final_end = evt.msg_end && !evt.retry_next;
	wire msg_halt  = final_end && ((pcfg_q[`PC_MSG_ERR_HALT] && any_err) ||
		(ext_en && pcfg_q[`PC_STS_MSG_HALT] && sts_set));
	wire err_acc   = frm_err_q || (final_end && any_err);
	wire sts_acc   = frm_sts_q || (final_end && sts_set);
	wire repeat_on = ext_en && pcfg_q[`PC_AUTO_REPEAT];
	wire frm_halt  = evt.frame_end && (!repeat_on ||
		(pcfg_q[`PC_FRM_ERR_HALT] && err_acc) ||
		(pcfg_q[`PC_STS_FRM_HALT] && sts_acc));
	wire stop_now  = (stop_req_q || cmd_stop) && (!msg_active || evt.msg_end);
	wire halt_ev   = bc_running_q && (msg_halt || frm_halt || stop_now);
	wire run_d     = (is_bc(mode_d) && !halt_ev && !do_abort && (bc_running_q ||
		cmd_start)) && !soft_rst;

	// register writes
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pcfg_q <= `PRIMARY_CFG_RESET;
			ecfg_q <= `EXT_CFG_RESET;
			scfg_q <= `STATUS_CFG_RESET;
		end else if (soft_rst) begin
			pcfg_q <= `PRIMARY_CFG_RESET;
			ecfg_q <= `EXT_CFG_RESET;
			scfg_q <= `STATUS_CFG_RESET;
		end else begin
			if (sel_pcfg)
				pcfg_q <= merge16(pcfg_q, wb_dat_i, wr_lo, wr_hi) & ~`PC_RO_MASK;
			if (sel_ecfg)
				ecfg_q <= merge16(ecfg_q, wb_dat_i, wr_lo, wr_hi);
			if (sel_scfg)
				scfg_q <= merge16(scfg_q, wb_dat_i, wr_lo, wr_hi);
		end
	end

	// engine-facing state
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mode_q       <= FULL_FUNCTION ? MODE_BC_PLAIN : MODE_IDLE;
			abort_q      <= 1'b0;
			bc_running_q <= 1'b0;
			halt_q       <= 1'b0;
			area_q       <= 1'b0;
			frm_err_q    <= 1'b0;
			frm_sts_q    <= 1'b0;
			stop_req_q   <= 1'b0;
			alt_status_q <= 1'b0;
		end else begin
			mode_q       <= mode_d;
			abort_q      <= do_abort;
			bc_running_q <= run_d;
			halt_q       <= halt_ev;
			area_q       <= area_nx;
			frm_err_q    <= (evt.frame_end || !bc_running_q) ? 1'b0 : err_acc;
			frm_sts_q    <= (evt.frame_end || !bc_running_q) ? 1'b0 : sts_acc;
			stop_req_q   <= run_d && !halt_ev && (stop_req_q || cmd_stop);
			// alternate status only counts once extended mode is on
			alt_status_q <= ext_en && ecfg_q[`EC_ALT_STATUS];
		end
	end

	// shared memory pointer locations follow the settled area
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ptr_q <= '{`AREA_A_STACK, `AREA_A_COUNT};
		end else begin
			ptr_q <= area_nx ? '{`AREA_B_STACK, `AREA_B_COUNT} :
				'{`AREA_A_STACK, `AREA_A_COUNT};
		end
	end

	// read data; the area bit reads the settled copy
	wire [15:0] pcfg_rd  = {pcfg_q[15:14], area_q, pcfg_q[12:3],
		bc_running_q, frame_active, msg_active};
	wire [15:0] state_rd = {8'h00, 1'b0, halt_q, abort_q, bc_running_q, 4'(mode_q)};
	wire [15:0] rd_mux   = sel_pcfg ? pcfg_rd : sel_ecfg ? ecfg_q : sel_scfg ? scfg_q :
		sel_state ? state_rd : 16'h0000;

	// classic single-cycle slave: ack one cycle after request, unmapped reads zero
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? {16'h0000, rd_mux} : 32'h0000_0000;
		end
	end

	// checks
	mode_idle_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(pcfg_q[15:14] == 2'b11 && !hold_mode) |=> (mode_q == MODE_IDLE))
		else $error("mode bits 11 did not select idle");
	mon_select_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(pcfg_q[15:14] == 2'b01 && !(pcfg_q[12] && ext_en)) |=> (mode_q == MODE_WORD_MON))
		else $error("word monitor not selected");
	rt_defer_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(msg_active && mode_q == MODE_RT_EXT && new_mode == MODE_RT_MON) |=>
		$stable(mode_q) || $past(evt.msg_end) || !$past(msg_active))
		else $error("RT mode swap took effect mid message");
	abort_mode_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(msg_active && is_rt(mode_q) && new_mode == MODE_BC_EXT) |=> abort_q)
		else $error("leaving RT mid message did not abort");
	quiet_idle_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(mode_q == MODE_RT_PLAIN && new_mode == MODE_IDLE) |=> !abort_q)
		else $error("plain RT to idle aborted");
	area_freeze_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(is_bc(mode_q) && frame_active && $past(frame_active)) |-> $stable(area_q))
		else $error("area changed inside a frame");
	msg_halt_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(bc_running_q && final_end && pcfg_q[12] && evt.timeout) |=>
		(halt_q && !bc_running_q))
		else $error("error halt missed");
	retry_go_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(bc_running_q && evt.msg_end && evt.retry_next && !evt.frame_end &&
		!stop_now && is_bc(mode_d) && !soft_rst) |=> bc_running_q)
		else $error("halt before retry");
	single_frame_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(bc_running_q && evt.frame_end && !repeat_on) |=> ##[0:1] !bc_running_q)
		else $error("single frame did not halt");
	ptr_area_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		ptr_q.stack_addr == (area_q ? `AREA_B_STACK : `AREA_A_STACK))
		else $error("pointer does not match area");
	abort_idle_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(msg_active && is_bc(mode_q) && new_mode == MODE_IDLE) |=> abort_q)
		else $error("leaving BC mid message did not abort");
	area_word_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(mode_q == MODE_WORD_MON && !soft_rst) |=> $stable(area_q))
		else $error("area moved in word monitor");
	sts_halt_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(bc_running_q && final_end && ext_en && pcfg_q[10] && sts_set) |=>
		(halt_q && !bc_running_q))
		else $error("status halt missed");
	frm_err_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(bc_running_q && evt.frame_end && repeat_on && pcfg_q[11] && err_acc) |=> halt_q)
		else $error("frame error halt missed");
	stop_cmd_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		(bc_running_q && stop_req_q && !msg_active) |=> !bc_running_q)
		else $error("stop did not halt at boundary");
	bus_ack_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
		wb_req |=> (wb_ack_o && !wb_req))
		else $error("bus request not acknowledged");
	start_cv: cover property (@(posedge mclk) disable iff (!rst_sync_n)
		!bc_running_q ##1 bc_running_q);
	halt_cv: cover property (@(posedge mclk) disable iff (!rst_sync_n)
		bc_running_q && frm_halt && repeat_on);
	abort_cv: cover property (@(posedge mclk) disable iff (!rst_sync_n) abort_q);
	defer_cv: cover property (@(posedge mclk) disable iff (!rst_sync_n) hold_mode [*3]);
	stop_cv: cover property (@(posedge mclk) disable iff (!rst_sync_n) stop_req_q && halt_ev);
endmodule : mode_ctrl
`default_nettype wire

/* testbench/engine_model.sv */
// protocol engine stand-in: message and frame activity with end-of-message events
`timescale 1ns/100ps
`default_nettype none
module engine_model (
	input  wire logic               mclk,
	output logic                    msg_active,
	output logic                    frame_active,
	output mode_ctrl_pkg::msg_evt_t evt
);
	import mode_ctrl_pkg::*;

	initial begin
		msg_active = 1'b0;
		frame_active = 1'b0;
		evt = '0;
	end

	task automatic begin_msg(input logic frm);
		@(posedge mclk);
		msg_active <= 1'b1;
		frame_active <= frm | frame_active;
	endtask : begin_msg

	// qualifiers mean nothing outside msg_end, so they are scrambled afterwards
	task automatic end_msg(input logic [3:0] er, input logic ry, input logic [7:0] st,
			input logic [15:0] cw, input logic fe);
		msg_evt_t e;
		e = '{1'b1, er[3], er[2], er[1], er[0], ry, st, cw, fe};
		@(posedge mclk);
		evt <= e;
		msg_active <= 1'b0;
		frame_active <= frame_active & ~fe;
		@(posedge mclk);
		evt <= {1'b0, ~e[29:1], 1'b0};
	endtask : end_msg
endmodule : engine_model
`default_nettype wire

/* testbench/mode_ctrl_test.sv */
// self-checking bench for mode decode, area switching and halt control
`timescale 1ns/100ps
`default_nettype none
`include "mode_ctrl_cfg.svh"
module mode_ctrl_test;
	import mode_ctrl_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, msg_active, frame_active, abort_q, bc_running_q, halt_q;
	logic        area_q, alt_status_q;
	msg_evt_t    evt;
	op_mode_t    mode_q;
	area_ptr_t   ptr_q;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;
	int          aborts = 0;
	int          halts = 0;

	mode_ctrl u_mode_ctrl (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .msg_active, .frame_active, .evt, .mode_q, .abort_q,
		.bc_running_q, .halt_q, .area_q, .ptr_q, .alt_status_q);
	engine_model u_engine_model (.mclk, .msg_active, .frame_active, .evt);

	initial begin
		forever #5 mclk = ~mclk;
	end

	// pulses are counted so a scenario can ask how many arrived in its window
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		aborts <= aborts + ((abort_q === 1'b1) ? 1 : 0);
		halts <= halts + ((halt_q === 1'b1) ? 1 : 0);
		if (cycles == 5000) begin
			miscompares++;
			end_sim;
		end
	end

	task end_sim;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
			output logic [31:0] r);
		int n;
		n = 0;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'h3;
		wb_dat_i <= {16'h0000, d};
		@(posedge mclk);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 50)
			miscompares++;
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		xfer(1'b0, a, 16'h0000, r);
	endtask : rd

	task reset_defaults;
		logic [31:0] r;
		check({28'h0, mode_q}, {28'h0, MODE_BC_PLAIN});
		check(ptr_q, {`AREA_A_STACK, `AREA_A_COUNT});
		rd(`OFS_PRIMARY_CFG, r);
		check(r, 32'h0000_0000);
		rd(8'h40, r);
		check(r, 32'h0000_0000);
		wr(`OFS_EXT_CFG, 16'h8000);
		wr(`OFS_EXT_CFG, 16'h8020);
		repeat (2) @(posedge mclk);
		check({31'h0, alt_status_q}, 32'h0000_0001);
	endtask : reset_defaults

	task mode_decode;
		logic [15:0] pv [12] = '{16'h0000, 16'h0000, 16'h4000, 16'h4000, 16'h5000, 16'h5000,
			16'h8000, 16'h9000, 16'h8000, 16'h9000, 16'hD000, 16'hC000};
		logic [11:0] ev = 12'h72a;
		op_mode_t mv [12] = '{MODE_BC_PLAIN, MODE_BC_EXT, MODE_WORD_MON, MODE_WORD_MON,
			MODE_WORD_MON, MODE_MSG_MON, MODE_RT_PLAIN, MODE_RT_PLAIN, MODE_RT_EXT,
			MODE_RT_MON, MODE_IDLE, MODE_IDLE};
		for (int i = 0; i < 12; i++) begin
			wr(`OFS_EXT_CFG, {ev[i], 15'h0000});
			wr(`OFS_PRIMARY_CFG, pv[i]);
			repeat (2) @(posedge mclk);
			check({28'h0, mode_q}, {28'h0, mv[i]});
		end
	endtask : mode_decode

	task automatic switch_mid(input logic e, input logic [15:0] f, input logic [15:0] t,
			input logic ab, input op_mode_t hold, input op_mode_t fin);
		int a0;
		wr(`OFS_EXT_CFG, {e, 15'h0000});
		wr(`OFS_PRIMARY_CFG, f);
		u_engine_model.begin_msg(1'b0);
		a0 = aborts;
		wr(`OFS_PRIMARY_CFG, t);
		repeat (2) @(posedge mclk);
		check(32'(aborts - a0), {31'h0, ab});
		check({28'h0, mode_q}, {28'h0, hold});
		u_engine_model.end_msg(4'h0, 1'b0, 8'h00, 16'h0000, 1'b0);
		repeat (2) @(posedge mclk);
		check({28'h0, mode_q}, {28'h0, fin});
	endtask : switch_mid

	task mode_changes;
		switch_mid(1'b1, 16'h8000, 16'h9000, 1'b0, MODE_RT_EXT, MODE_RT_MON);
		switch_mid(1'b1, 16'h9000, 16'h8000, 1'b0, MODE_RT_MON, MODE_RT_EXT);
		switch_mid(1'b1, 16'h8000, 16'h0000, 1'b1, MODE_BC_EXT, MODE_BC_EXT);
		switch_mid(1'b0, 16'h8000, 16'hC000, 1'b0, MODE_IDLE, MODE_IDLE);
		switch_mid(1'b0, 16'h0000, 16'hC000, 1'b1, MODE_IDLE, MODE_IDLE);
		switch_mid(1'b1, 16'h0000, 16'hC000, 1'b1, MODE_IDLE, MODE_IDLE);
	endtask : mode_changes

	task area_switch;
		logic [31:0] r;
		wr(`OFS_EXT_CFG, 16'h0000);
		wr(`OFS_PRIMARY_CFG, 16'h8000);
		u_engine_model.begin_msg(1'b0);
		wr(`OFS_PRIMARY_CFG, 16'hA000);
		rd(`OFS_PRIMARY_CFG, r);
		check(r & 32'h0000_2000, 32'h0000_0000);
		check({31'h0, area_q}, 32'h0000_0000);
		u_engine_model.end_msg(4'h0, 1'b0, 8'h00, 16'h0000, 1'b0);
		repeat (2) @(posedge mclk);
		rd(`OFS_PRIMARY_CFG, r);
		check(r & 32'h0000_2000, 32'h0000_2000);
		check(ptr_q, {`AREA_B_STACK, `AREA_B_COUNT});
		wr(`OFS_PRIMARY_CFG, 16'h6000);
		wr(`OFS_PRIMARY_CFG, 16'h4000);
		repeat (2) @(posedge mclk);
		check({31'h0, area_q}, 32'h0000_0001);
	endtask : area_switch

	task soft_reset;
		logic [31:0] r;
		wr(`OFS_PRIMARY_CFG, 16'h8000);
		wr(`OFS_COMMAND, 16'h0004);
		rd(`OFS_PRIMARY_CFG, r);
		check(r, 32'h0000_0000);
		check({28'h0, mode_q}, {28'h0, MODE_BC_PLAIN});
		check(ptr_q, {`AREA_A_STACK, `AREA_A_COUNT});
	endtask : soft_reset

	// stop while a message runs waits for its end, then halts
	task stop_cmd;
		int h0;
		wr(`OFS_EXT_CFG, 16'h8000);
		wr(`OFS_PRIMARY_CFG, 16'h0100);
		wr(`OFS_STATUS_CFG, 16'h0000);
		wr(`OFS_COMMAND, 16'h0001);
		h0 = halts;
		u_engine_model.begin_msg(1'b1);
		wr(`OFS_COMMAND, 16'h0002);
		repeat (2) @(posedge mclk);
		check(32'(halts - h0), 32'h0000_0000);
		u_engine_model.end_msg(4'h0, 1'b0, 8'h00, 16'h0000, 1'b0);
		repeat (3) @(posedge mclk);
		check(32'(halts - h0), 32'h0000_0001);
		check({31'h0, bc_running_q}, 32'h0000_0000);
	endtask : stop_cmd

	// one bc message; a halt may only land after its end, never while it runs
	task automatic hr(input logic e, input logic [15:0] p, input logic [15:0] s, input logic go,
			input logic [3:0] er, input logic ry, input logic [7:0] st, input logic [15:0] cw,
			input logic fe, input logic x);
		int h0;
		if (go) begin
			wr(`OFS_EXT_CFG, {e, 15'h0000});
			wr(`OFS_PRIMARY_CFG, p);
			wr(`OFS_STATUS_CFG, s);
			wr(`OFS_COMMAND, 16'h0001);
		end
		h0 = halts;
		u_engine_model.begin_msg(1'b1);
		repeat (3) @(posedge mclk);
		check(32'(halts - h0), 32'h0000_0000);
		u_engine_model.end_msg(er, ry, st, cw, fe);
		repeat (3) @(posedge mclk);
		check(32'(halts - h0), {31'h0, x});
		check({31'h0, bc_running_q}, {31'h0, ~x});
	endtask : hr

	task error_halts;
		for (int i = 0; i < 4; i++) begin
			hr(1'b0, 16'h1000, 16'h0000, 1'b1, 4'(1 << i), 1'b0, 8'h00, 16'h0000, 1'b0, 1'b1);
		end
		hr(1'b0, 16'h1000, 16'h0000, 1'b1, 4'h2, 1'b1, 8'h00, 16'h0000, 1'b0, 1'b0);
		hr(1'b0, 16'h1000, 16'h0000, 1'b0, 4'h0, 1'b0, 8'h00, 16'h0000, 1'b0, 1'b0);
	endtask : error_halts

	task frame_halts;
		hr(1'b1, 16'h0900, 16'h0000, 1'b1, 4'h4, 1'b0, 8'h00, 16'h0000, 1'b0, 1'b0);
		hr(1'b1, 16'h0900, 16'h0000, 1'b0, 4'h0, 1'b0, 8'h00, 16'h0000, 1'b1, 1'b1);
		hr(1'b1, 16'h0900, 16'h0000, 1'b1, 4'h4, 1'b1, 8'h00, 16'h0000, 1'b0, 1'b0);
		hr(1'b1, 16'h0900, 16'h0000, 1'b0, 4'h0, 1'b0, 8'h00, 16'h0000, 1'b1, 1'b0);
		hr(1'b1, 16'h0000, 16'h0000, 1'b1, 4'h0, 1'b0, 8'h00, 16'h0000, 1'b1, 1'b1);
		hr(1'b1, 16'h0300, 16'h0000, 1'b1, 4'h0, 1'b0, 8'h04, 16'h0000, 1'b0, 1'b0);
		hr(1'b1, 16'h0300, 16'h0000, 1'b0, 4'h0, 1'b0, 8'h00, 16'h0000, 1'b1, 1'b1);
	endtask : frame_halts

	task status_halts;
		hr(1'b1, 16'h0400, 16'h0000, 1'b1, 4'h0, 1'b0, 8'h01, 16'h0008, 1'b0, 1'b0);
		hr(1'b1, 16'h0400, 16'h0000, 1'b1, 4'h0, 1'b0, 8'h01, 16'h0000, 1'b0, 1'b1);
		hr(1'b1, 16'h0400, 16'h0000, 1'b1, 4'h0, 1'b0, 8'h80, 16'h0000, 1'b0, 1'b1);
		hr(1'b1, 16'h0400, 16'h0800, 1'b1, 4'h0, 1'b0, 8'h00, 16'h0008, 1'b0, 1'b0);
		hr(1'b1, 16'h0400, 16'h0800, 1'b1, 4'h0, 1'b0, 8'h01, 16'h0000, 1'b0, 1'b1);
		hr(1'b1, 16'h0400, 16'h1000, 1'b1, 4'h0, 1'b0, 8'h04, 16'h0200, 1'b0, 1'b0);
		hr(1'b1, 16'h0400, 16'h1000, 1'b1, 4'h0, 1'b0, 8'h04, 16'h0000, 1'b0, 1'b1);
		hr(1'b1, 16'h0400, 16'h0000, 1'b1, 4'h0, 1'b1, 8'h04, 16'h0000, 1'b0, 1'b0);
	endtask : status_halts

	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		reset_defaults;
		mode_decode;
		mode_changes;
		area_switch;
		soft_reset;
		error_halts;
		frame_halts;
		status_halts;
		stop_cmd;
		end_sim;
	end
endmodule : mode_ctrl_test
`default_nettype wire
